/* File: rxoh_pkg.sv */
// rxoh_pkg: offsets, field positions and carrier types for the per-port
// receive overhead and status register group.
// assumes one port instance; the per-port stride is decoded outside.
`default_nettype none

package rxoh_pkg;

    ////////////////////////////////////////////////////////////////////////
    // bus widths
    localparam int unsigned ADDR_W = 9;
    localparam int unsigned DATA_W = 8;

    ////////////////////////////////////////////////////////////////////////
    // register offsets within one port
    localparam logic [8:0] OFF_FEA_HIGH = 9'h058;
    localparam logic [8:0] OFF_FEA_LOW = 9'h059;
    localparam logic [8:0] OFF_FEB_HIGH = 9'h05A;
    localparam logic [8:0] OFF_FEB_LOW = 9'h05B;
    localparam logic [8:0] OFF_CONFIG = 9'h05E;
    localparam logic [8:0] OFF_MON_SELECT = 9'h05F;
    localparam logic [8:0] OFF_MONITOR = 9'h060;
    localparam logic [8:0] OFF_LINK = 9'h062;
    localparam logic [8:0] OFF_CODE = 9'h063;
    localparam logic [8:0] OFF_CAPTURE1 = 9'h064;
    localparam logic [8:0] OFF_CAPTURE2 = 9'h065;
    localparam logic [8:0] OFF_CAPTURE3 = 9'h066;
    localparam logic [8:0] OFF_INTL_ODD = 9'h067;

    ////////////////////////////////////////////////////////////////////////
    // config register fields
    localparam int CFG_E1_BIT = 0;
    localparam int CFG_CRC4_BIT = 1;
    localparam int CFG_D4_BIT = 2;
    localparam logic [2:0] CFG_RESET = 3'h0;
    localparam logic [4:0] SEL_RESET = 5'h00;

    // sync status fields and counter limits
    localparam int STS_CRC4_BIT = 2;
    localparam int STS_CAS_BIT = 1;
    localparam int STS_FAS_BIT = 0;
    localparam logic [5:0] SEARCH_MAX = 6'h3F;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [2:0] LAST_BIT_INDEX = 3'h7;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // framer side carrier, all on the register clock
    typedef struct packed {
        logic fea_err;
        logic feb_err;
        logic ds0_valid;
        logic ds0_bit;
        logic [4:0] ds0_slot;
        logic [2:0] ds0_index;
        logic fdl_valid;
        logic fdl_bit;
        logic fs_valid;
        logic fs_bit;
        logic mf_boundary;
        logic boc_valid;
        logic [5:0] boc_code;
        logic crc4_timeout;
        logic crc4_locked;
        logic crc4_mf_searching;
        logic cas_mf_searching;
        logic frame_align_searching;
        logic slc_valid;
        logic [23:0] slc_bits;
        logic align_valid;
        logic [7:0] align_byte;
        logic nonalign_valid;
        logic [7:0] nonalign_byte;
        logic intl_valid;
        logic [3:0] intl_frame;
        logic frame_international_bit;
    } rxoh_framer_type;

    // register port carrier
    typedef struct packed {
        logic [8:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rxoh_bus_type;

    // whole state of the register group
    typedef struct packed {
        logic [2:0] cfg;
        logic [4:0] mon_select;
        logic [15:0] far_end_a_count;
        logic [15:0] far_end_b_count;
        logic [7:0] mon_shift;
        logic [7:0] monitor;
        logic [7:0] fdl_shift;
        logic [2:0] fdl_count;
        logic [5:0] fs_shift;
        logic [7:0] link_byte;
        logic [5:0] rx_code_bits;
        logic [5:0] crc4_search_count;
        logic [23:0] slc;
        logic [7:0] align_byte;
        logic [7:0] nonalign_byte;
        logic [15:0] intl;
        logic [7:0] rd_data;
    } rxoh_state_type;

endpackage

`default_nettype wire

/* File: rxoh_regs.sv */
// rxoh_regs: one port of the receive overhead and status registers.
// assumes framer inputs and register port share clk; no synchronisers.
`timescale 1ns/1ps
`default_nettype none

module rxoh_regs
    import rxoh_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire rxoh_bus_type bus_i,
    input wire rxoh_framer_type framer_i,
    output logic [7:0] rd_data
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // saturating 16-bit error counter step
    function automatic logic [15:0] sat_inc16(input logic [15:0] v,
                                              input logic ev);
        logic [15:0] r;
        r = v;
        if (ev && (v != COUNT_MAX)) begin
            r = v + 16'h0001;
        end
        return r;
    endfunction

    // pick even or odd frame international bits, highest frame at bit 7
    function automatic logic [7:0] pick_intl(input logic [15:0] v,
                                             input logic odd);
        logic [7:0] r;
        r = BYTE_RESET;
        for (int k = 0; k < 8; k++) begin
            r[k] = v[2 * k + (odd ? 1 : 0)];
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state

    rxoh_state_type s_q;
    rxoh_state_type s_d;
    logic e1_mode;
    logic crc4_en;
    logic d4_mode;
    logic [7:0] sync_status;

    // mode decode and live sync status
    assign e1_mode = s_q.cfg[CFG_E1_BIT];
    assign crc4_en = s_q.cfg[CFG_CRC4_BIT];
    assign d4_mode = s_q.cfg[CFG_D4_BIT];
    assign sync_status = {s_q.crc4_search_count[5:2],
                          s_q.crc4_search_count[0],
                          framer_i.crc4_mf_searching,
                          framer_i.cas_mf_searching,
                          framer_i.frame_align_searching};

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        s_d = s_q;

        // error counters
        s_d.far_end_a_count = sat_inc16(s_q.far_end_a_count,
                                        framer_i.fea_err);
        s_d.far_end_b_count = sat_inc16(s_q.far_end_b_count,
                                        framer_i.feb_err);

        // selected channel monitor, shifts in at bit 0
        if (framer_i.ds0_valid && (framer_i.ds0_slot == s_q.mon_select)) begin
            s_d.mon_shift = {s_q.mon_shift[6:0], framer_i.ds0_bit};
            if (framer_i.ds0_index == LAST_BIT_INDEX) begin
                s_d.monitor = {s_q.mon_shift[6:0], framer_i.ds0_bit};
            end
        end

        // T1 data link: esf byte path or D4 Fs path
        if (!e1_mode && !d4_mode && framer_i.fdl_valid) begin
            s_d.fdl_shift = {framer_i.fdl_bit, s_q.fdl_shift[7:1]};
            s_d.fdl_count = s_q.fdl_count + 3'h1;
            if (s_q.fdl_count == LAST_BIT_INDEX) begin
                s_d.link_byte = {framer_i.fdl_bit,
                                 s_q.fdl_shift[7:1]};
            end
        end
        if (!e1_mode && d4_mode) begin
            if (framer_i.fs_valid) begin
                s_d.fs_shift = {framer_i.fs_bit, s_q.fs_shift[5:1]};
            end
            if (framer_i.mf_boundary) begin
                s_d.link_byte = {2'h0, s_q.fs_shift};
            end
        end

        // bit-oriented code
        if (!e1_mode && framer_i.boc_valid) begin
            s_d.rx_code_bits = framer_i.boc_code;
        end

        // CRC-4 search counter
        if (!crc4_en || framer_i.crc4_locked) begin
            s_d.crc4_search_count = 6'h00;
        end else if (e1_mode && framer_i.crc4_timeout &&
                     (s_q.crc4_search_count != SEARCH_MAX)) begin
            s_d.crc4_search_count = s_q.crc4_search_count + 6'h01;
        end

        // T1 SLC-96 captures
        if (!e1_mode && framer_i.slc_valid) begin
            s_d.slc = framer_i.slc_bits;
        end

        // E1 timeslot zero captures
        if (e1_mode && framer_i.align_valid) begin
            s_d.align_byte = framer_i.align_byte;
        end
        if (e1_mode && framer_i.nonalign_valid) begin
            s_d.nonalign_byte = framer_i.nonalign_byte;
        end
        if (e1_mode && framer_i.intl_valid) begin
            s_d.intl[framer_i.intl_frame] =
                framer_i.frame_international_bit;
        end

        // only the config and select registers take writes
        if (bus_i.wr) begin
            if (bus_i.addr == OFF_CONFIG) begin
                s_d.cfg = bus_i.wdata[2:0];
            end else if (bus_i.addr == OFF_MON_SELECT) begin
                s_d.mon_select = bus_i.wdata[4:0];
            end
        end

        // read data stands one cycle after the strobe only
        s_d.rd_data = BYTE_RESET;
        if (bus_i.rd) begin
            case (bus_i.addr)
                OFF_FEA_HIGH: s_d.rd_data = s_q.far_end_a_count[15:8];
                OFF_FEA_LOW: s_d.rd_data = s_q.far_end_a_count[7:0];
                OFF_FEB_HIGH: s_d.rd_data = s_q.far_end_b_count[15:8];
                OFF_FEB_LOW: s_d.rd_data = s_q.far_end_b_count[7:0];
                OFF_CONFIG: s_d.rd_data = {5'h00, s_q.cfg};
                OFF_MON_SELECT: s_d.rd_data = {3'h0, s_q.mon_select};
                OFF_MONITOR: s_d.rd_data = s_q.monitor;
                OFF_LINK: s_d.rd_data = e1_mode ? sync_status
                                                : s_q.link_byte;
                OFF_CODE: s_d.rd_data = e1_mode ? BYTE_RESET
                                                : {2'h0, s_q.rx_code_bits};
                OFF_CAPTURE1: s_d.rd_data = e1_mode ? s_q.align_byte
                                                    : s_q.slc[7:0];
                OFF_CAPTURE2: s_d.rd_data = e1_mode ? s_q.nonalign_byte
                                                    : s_q.slc[15:8];
                OFF_CAPTURE3: s_d.rd_data = e1_mode ? pick_intl(s_q.intl, 1'h0)
                                                    : s_q.slc[23:16];
                OFF_INTL_ODD: s_d.rd_data = e1_mode ? pick_intl(s_q.intl, 1'h1)
                                                    : BYTE_RESET;
                default: s_d.rd_data = BYTE_RESET;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers, synchronous reset clears the whole group
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rd_data = s_q.rd_data;

    ////////////////////////////////////////////////////////////////////////
    // checks

    // no read strobe, no read data
    a_read_idle_zero: assert property (@(posedge clk) disable iff (rst)
        !bus_i.rd |=> (rd_data == BYTE_RESET))
        else $error("read data not zero after idle cycle");

    // writes never disturb the error counter
    a_write_no_effect: assert property (@(posedge clk) disable iff (rst)
        (bus_i.wr && !framer_i.fea_err) |=> $stable(s_q.far_end_a_count))
        else $error("write changed far-end A count");

    // far-end B counter steps by one per error
    a_feb_step: assert property (@(posedge clk) disable iff (rst)
        (framer_i.feb_err && (s_q.far_end_b_count != COUNT_MAX)) |=>
        (s_q.far_end_b_count == $past(s_q.far_end_b_count) + 16'h0001))
        else $error("far-end B count did not step");

    // high byte of A pair reads back the counter
    a_fea_pair: assert property (@(posedge clk) disable iff (rst)
        (bus_i.rd && (bus_i.addr == OFF_FEA_HIGH)) |=>
        (rd_data == $past(s_q.far_end_a_count[15:8])))
        else $error("far-end A high byte wrong");

    // monitor last bit lands in bit 0
    a_monitor_order: assert property (@(posedge clk) disable iff (rst)
        (framer_i.ds0_valid && (framer_i.ds0_slot == s_q.mon_select) &&
         (framer_i.ds0_index == LAST_BIT_INDEX)) |=>
        (s_q.monitor[0] == $past(framer_i.ds0_bit)) &&
        (s_q.monitor[7:1] == $past(s_q.mon_shift[6:0])))
        else $error("channel monitor order wrong");

    // D4 link register moves only at multiframe boundary
    a_d4_hold: assert property (@(posedge clk) disable iff (rst)
        (!e1_mode && d4_mode && !framer_i.mf_boundary) |=>
        $stable(s_q.link_byte))
        else $error("D4 link byte changed off boundary");

    // bit-oriented code taken as received
    a_code_capture: assert property (@(posedge clk) disable iff (rst)
        (!e1_mode && framer_i.boc_valid) |=>
        (s_q.rx_code_bits == $past(framer_i.boc_code)))
        else $error("bit-oriented code not captured");

    // search counter step on interval expiry
    a_search_step: assert property (@(posedge clk) disable iff (rst)
        (e1_mode && crc4_en && !framer_i.crc4_locked &&
         framer_i.crc4_timeout && (s_q.crc4_search_count != SEARCH_MAX))
        |=> (s_q.crc4_search_count ==
             $past(s_q.crc4_search_count) + 6'h01))
        else $error("search counter did not step");

    // search counter cleared by lock or mode off
    a_search_clear: assert property (@(posedge clk) disable iff (rst)
        (!crc4_en || framer_i.crc4_locked) |=>
        (s_q.crc4_search_count == 6'h00))
        else $error("search counter not cleared");

    // search counter holds at its ceiling
    a_search_sat: assert property (@(posedge clk) disable iff (rst)
        (crc4_en && !framer_i.crc4_locked &&
         (s_q.crc4_search_count == SEARCH_MAX)) |=>
        (s_q.crc4_search_count == SEARCH_MAX))
        else $error("search counter wrapped");

    // E1 status read shows live flags of the strobe cycle
    a_status_live: assert property (@(posedge clk) disable iff (rst)
        (bus_i.rd && e1_mode && (bus_i.addr == OFF_LINK)) |=>
        (rd_data[2:0] == {$past(framer_i.crc4_mf_searching),
                          $past(framer_i.cas_mf_searching),
                          $past(framer_i.frame_align_searching)}))
        else $error("live sync status wrong");

    // low byte of A pair reads back the counter
    a_fea_low_read: assert property (@(posedge clk) disable iff (rst)
        (bus_i.rd && (bus_i.addr == OFF_FEA_LOW)) |=>
        (rd_data == $past(s_q.far_end_a_count[7:0])))
        else $error("far-end A low byte wrong");

    // eighth data link bit commits the byte, first bit at bit 0
    a_link_commit: assert property (@(posedge clk) disable iff (rst)
        (!e1_mode && !d4_mode && framer_i.fdl_valid &&
         (s_q.fdl_count == LAST_BIT_INDEX)) |=>
        (s_q.link_byte == {$past(framer_i.fdl_bit),
                           $past(s_q.fdl_shift[7:1])}))
        else $error("data link byte not committed");

    // D4 boundary commits the six Fs bits under two zero bits
    a_d4_commit: assert property (@(posedge clk) disable iff (rst)
        (!e1_mode && d4_mode && framer_i.mf_boundary) |=>
        (s_q.link_byte == {2'h0, $past(s_q.fs_shift)}))
        else $error("D4 link byte not committed");

    // T1 code read has its two top bits at zero
    a_code_read: assert property (@(posedge clk) disable iff (rst)
        (bus_i.rd && !e1_mode && (bus_i.addr == OFF_CODE)) |=>
        (rd_data == {2'h0, $past(s_q.rx_code_bits)}))
        else $error("bit-oriented code read wrong");

    // E1 status read shows counter bits 5:2 and 0, bit 1 left out
    a_status_count: assert property (@(posedge clk) disable iff (rst)
        (bus_i.rd && e1_mode && (bus_i.addr == OFF_LINK)) |=>
        (rd_data[7:4] == $past(s_q.crc4_search_count[5:2])) &&
        (rd_data[3] == $past(s_q.crc4_search_count[0])))
        else $error("search count read wrong");

    // CRC-4 multiframe search flag at its status bit
    a_crc4_flag: assert property (@(posedge clk) disable iff (rst)
        (bus_i.rd && e1_mode && (bus_i.addr == OFF_LINK)) |=>
        (rd_data[STS_CRC4_BIT] == $past(framer_i.crc4_mf_searching)))
        else $error("CRC-4 search flag wrong");

    // CAS multiframe search flag at its status bit
    a_cas_flag: assert property (@(posedge clk) disable iff (rst)
        (bus_i.rd && e1_mode && (bus_i.addr == OFF_LINK)) |=>
        (rd_data[STS_CAS_BIT] == $past(framer_i.cas_mf_searching)))
        else $error("CAS search flag wrong");

    // frame alignment search flag at its status bit
    a_fas_flag: assert property (@(posedge clk) disable iff (rst)
        (bus_i.rd && e1_mode && (bus_i.addr == OFF_LINK)) |=>
        (rd_data[STS_FAS_BIT] == $past(framer_i.frame_align_searching)))
        else $error("frame align search flag wrong");

    // T1 read at the link offset returns the data link byte
    a_t1_link_read: assert property (@(posedge clk) disable iff (rst)
        (bus_i.rd && !e1_mode && (bus_i.addr == OFF_LINK)) |=>
        (rd_data == $past(s_q.link_byte)))
        else $error("T1 link byte read wrong");

    // SLC-96 bits taken whole in T1
    a_slc_take: assert property (@(posedge clk) disable iff (rst)
        (!e1_mode && framer_i.slc_valid) |=>
        (s_q.slc == $past(framer_i.slc_bits)))
        else $error("SLC-96 bits not captured");

    // international bit lands at its frame position
    a_intl_take: assert property (@(posedge clk) disable iff (rst)
        (e1_mode && framer_i.intl_valid) |=>
        (s_q.intl[$past(framer_i.intl_frame)] ==
         $past(framer_i.frame_international_bit)))
        else $error("international bit not captured");

endmodule

`default_nettype wire

/* File: rxoh_line_model.sv */
// rxoh_line_model: receive framer stand-in that drives the overhead inputs.
// assumes its tasks are called after reset, from one process at a time.
`timescale 1ns/1ps
`default_nettype none

module rxoh_line_model
    import rxoh_pkg::*;
(
    input wire logic clk,
    output var rxoh_framer_type framer_o
);
    logic [2:0] lvl_now = 3'h0;

    ////////////////////////////////////////////////////////////////////////
    // idle inputs at time zero
    initial begin
        framer_o = '0;
    end

    // search levels ride under every pulse: crc4, cas, fas
    function automatic rxoh_framer_type merge(input rxoh_framer_type v);
        merge = v;
        merge.crc4_mf_searching = lvl_now[2];
        merge.cas_mf_searching = lvl_now[1];
        merge.frame_align_searching = lvl_now[0];
    endfunction

    // change the live search levels after an edge
    task automatic set_lvl(input logic [2:0] lv);
        @(posedge clk);
        lvl_now = lv;
        framer_o <= merge('0);
    endtask

    // one-cycle event pulse, then back to idle
    task automatic pulse(input rxoh_framer_type v);
        @(posedge clk);
        framer_o <= merge(v);
        @(posedge clk);
        framer_o <= merge('0);
    endtask
endmodule

`default_nettype wire

/* File: tb_top.sv */
// tb_top: self-checking bench for one port of the overhead register group.
// assumes rxoh_regs and rxoh_line_model share the 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import rxoh_pkg::*;

    localparam logic [7:0] MON_PAT = 8'hB2;
    localparam logic [7:0] FDL_PAT = 8'h4D;
    localparam logic [5:0] FS_PAT = 6'h2D;
    logic clk = 1'h0;
    logic rst = 1'h1;
    rxoh_bus_type bus = '0;
    rxoh_framer_type fr;
    rxoh_framer_type f;
    logic [7:0] rd_data;
    int err_total = 0;
    int compares = 0;

    ////////////////////////////////////////////////////////////////////////
    // 40 ns clock
    always #20 clk = ~clk;

    rxoh_regs uut (
        .clk(clk),
        .rst(rst),
        .bus_i(bus),
        .framer_i(fr),
        .rd_data(rd_data)
    );

    rxoh_line_model fm (
        .clk(clk),
        .framer_o(fr)
    );

    ////////////////////////////////////////////////////////////////////////
    // one-cycle write strobe
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'h1;
        @(posedge clk);
        bus.wr <= 1'h0;
    endtask

    // read strobe, data checked in the following cycle only
    task automatic rd_chk(input logic [8:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus.addr <= a;
        bus.rd <= 1'h1;
        @(posedge clk);
        bus.rd <= 1'h0;
        #1;
        compares++;
        if (rd_data !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t addr %h got %h exp %h",
                $time, a, rd_data, exp);
        end
    endtask

    // verdict and end of run
    task automatic print_verdict;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        for (int i = 0; i < 16; i++) begin
            rd_chk(9'h058 + i[8:0], 8'h00);
        end
        // far-end counters: A = 3, B = 0x0102
        f = '0;
        f.fea_err = 1'h1;
        repeat (3) fm.pulse(f);
        f = '0;
        f.feb_err = 1'h1;
        repeat (258) fm.pulse(f);
        wr(OFF_FEA_LOW, 8'hFF);
        rd_chk(OFF_FEA_HIGH, 8'h00);
        rd_chk(OFF_FEA_LOW, 8'h03);
        rd_chk(OFF_FEB_HIGH, 8'h01);
        rd_chk(OFF_FEB_LOW, 8'h02);
        rd_chk(9'h070, 8'h00);
        // channel 5 monitor, channel 6 carries the inverse
        wr(OFF_MON_SELECT, 8'h05);
        for (int i = 0; i < 8; i++) begin
            f = '0;
            f.ds0_valid = 1'h1;
            f.ds0_index = i[2:0];
            f.ds0_slot = 5'h06;
            f.ds0_bit = ~MON_PAT[7 - i];
            fm.pulse(f);
            f.ds0_slot = 5'h05;
            f.ds0_bit = MON_PAT[7 - i];
            fm.pulse(f);
        end
        rd_chk(OFF_MONITOR, 8'hB2);
        // T1 data link byte, first bit lands in bit 0
        for (int i = 0; i < 8; i++) begin
            f = '0;
            f.fdl_valid = 1'h1;
            f.fdl_bit = FDL_PAT[i];
            fm.pulse(f);
        end
        rd_chk(OFF_LINK, 8'h4D);
        f = '0;
        f.boc_valid = 1'h1;
        f.boc_code = 6'h2A;
        fm.pulse(f);
        rd_chk(OFF_CODE, 8'h2A);
        f = '0;
        f.slc_valid = 1'h1;
        f.slc_bits = 24'hABCDEF;
        fm.pulse(f);
        rd_chk(OFF_CAPTURE1, 8'hEF);
        rd_chk(OFF_CAPTURE2, 8'hCD);
        rd_chk(OFF_CAPTURE3, 8'hAB);
        // D4 framing: six Fs bits, committed only at the multiframe edge
        wr(OFF_CONFIG, 8'h04);
        for (int i = 0; i < 6; i++) begin
            f = '0;
            f.fs_valid = 1'h1;
            f.fs_bit = FS_PAT[i];
            fm.pulse(f);
        end
        rd_chk(OFF_LINK, 8'h4D);
        f = '0;
        f.mf_boundary = 1'h1;
        fm.pulse(f);
        rd_chk(OFF_LINK, 8'h2D);
        // E1 with CRC-4: live search flags
        wr(OFF_CONFIG, 8'h03);
        fm.set_lvl(3'h5);
        rd_chk(OFF_LINK, 8'h05);
        fm.set_lvl(3'h2);
        rd_chk(OFF_LINK, 8'h02);
        fm.set_lvl(3'h0);
        rd_chk(OFF_CODE, 8'h00);
        // search counter: 5 reads 0x18, saturated 63 reads 0xF8
        f = '0;
        f.crc4_timeout = 1'h1;
        repeat (5) fm.pulse(f);
        rd_chk(OFF_LINK, 8'h18);
        repeat (70) fm.pulse(f);
        rd_chk(OFF_LINK, 8'hF8);
        f = '0;
        f.crc4_locked = 1'h1;
        fm.pulse(f);
        rd_chk(OFF_LINK, 8'h00);
        f = '0;
        f.crc4_timeout = 1'h1;
        repeat (3) fm.pulse(f);
        rd_chk(OFF_LINK, 8'h08);
        wr(OFF_CONFIG, 8'h01);
        rd_chk(OFF_LINK, 8'h00);
        fm.pulse(f);
        rd_chk(OFF_LINK, 8'h00);
        // frame bytes and international bits of frames 0, 3, 6, 9, 12, 15
        f = '0;
        f.align_valid = 1'h1;
        f.align_byte = 8'h9B;
        f.nonalign_valid = 1'h1;
        f.nonalign_byte = 8'hDF;
        fm.pulse(f);
        rd_chk(OFF_CAPTURE1, 8'h9B);
        rd_chk(OFF_CAPTURE2, 8'hDF);
        for (int i = 0; i < 16; i++) begin
            f = '0;
            f.intl_valid = 1'h1;
            f.intl_frame = i[3:0];
            f.frame_international_bit = (i % 3 == 0);
            fm.pulse(f);
        end
        rd_chk(OFF_CAPTURE3, 8'h49);
        rd_chk(OFF_INTL_ODD, 8'h92);
        print_verdict();
    end
endmodule

`default_nettype wire
